/* File: src/bfs_defs.svh */
`ifndef BFS_DEFS_SVH
`define BFS_DEFS_SVH

// Register byte offsets on the Wishbone bus.
`define BFS_OFF_CTRL      8'h00
`define BFS_OFF_THR0      8'h04
`define BFS_OFF_THR1      8'h08
`define BFS_OFF_THR2      8'h0c
`define BFS_OFF_THR3      8'h10
`define BFS_OFF_TIME      8'h14
`define BFS_OFF_STATUS    8'h18
`define BFS_OFF_IRQ_STAT  8'h1c
`define BFS_OFF_IRQ_CLR   8'h20
`define BFS_OFF_IRQ_EN    8'h24
`define BFS_OFF_OPER_ACK  8'h28
`define BFS_OFF_COUNT     8'h2c

// Control register fields.
`define BFS_CTRL_EN       0
`define BFS_CTRL_SCH_LO   1
`define BFS_CTRL_SCH_HI   2
`define BFS_CTRL_RELAY    3
`define BFS_CTRL_LINK     4
`define BFS_CTRL_MASK_LO  5
`define BFS_CTRL_MASK_HI  8
`define BFS_CTRL_SET_LO   9
`define BFS_CTRL_SET_HI   10
`define BFS_CTRL_SET_PIN  11
`define BFS_CTRL_RST      12'h9f9

// Status register fields.
`define BFS_ST_RUN        2
`define BFS_ST_TRIP       3
`define BFS_ST_LOCK       4
`define BFS_ST_OPEN       5
`define BFS_ST_SET_LO     6
`define BFS_ST_SET_HI     7
`define BFS_ST_HASCUR     8

// Interrupt bits: trip, rejected, timer started.
`define BFS_IRQ_TRIP      0
`define BFS_IRQ_REJ       1
`define BFS_IRQ_START     2
`define BFS_IRQ_W         3

// Reset values and timing.
`define BFS_THR_RST       16'h0100
`define BFS_SUP_TIME_US   100
`define BFS_CLK_MHZ       200

`endif

/* File: src/bfs_pkg.sv */
`default_nettype none
package bfs_pkg;
	// Supervision state of the monitor.
	typedef enum logic [1:0] {
		BFS_STANDBY  = 2'b00,
		BFS_RUNNING  = 2'b01,
		BFS_REJECTED = 2'b10,
		BFS_TRIPPED  = 2'b11
	} bfs_state_t;

	// Evidence scheme that stops the supervision timer.
	typedef enum logic [1:0] {
		BFS_SCH_CURRENT  = 2'b00,
		BFS_SCH_POSITION = 2'b01,
		BFS_SCH_COMBINED = 2'b10,
		BFS_SCH_RSVD     = 2'b11
	} bfs_scheme_t;
endpackage : bfs_pkg
`default_nettype wire

/* File: src/bfs_tmr_if.sv */
`default_nettype none
// Control and status of the supervision timer.
interface bfs_tmr_if;
	logic        start;
	logic        stop;
	logic [31:0] limit;
	logic        running;
	logic        expired;
	logic [31:0] count;

	modport ctl (output start, output stop, output limit, input running, input expired, input count);
	modport tmr (input start, input stop, input limit, output running, output expired, output count);
endinterface : bfs_tmr_if
`default_nettype wire

/* File: src/bfs_timer.sv */
`default_nettype none
module bfs_timer (
	input  wire logic clk_in,   // System clock.
	input  wire logic rst_in,   // Synchronous reset, active high.
	bfs_tmr_if.tmr    tmr       // Timer control and status.
);
	logic        run_q;
	logic [31:0] cnt_q;

	// A stop wins over the start and over expiry, so an opened breaker never trips.
	always_ff @(posedge clk_in) begin
		if (rst_in || tmr.stop) begin
			run_q <= 1'b0;
			cnt_q <= 32'h0;
		end else if (tmr.start && !run_q) begin
			run_q <= 1'b1;
			cnt_q <= 32'h1;
		end else if (run_q) begin
			if (cnt_q >= tmr.limit) begin
				run_q <= 1'b0;
			end else begin
				cnt_q <= cnt_q + 32'h1;
			end
		end
	end

	// Expiry is a single-cycle pulse in the last counted cycle.
	assign tmr.running = run_q;
	assign tmr.expired = run_q && !tmr.stop && (cnt_q >= tmr.limit);
	assign tmr.count   = cnt_q;
endmodule : bfs_timer
`default_nettype wire

/* File: src/bfs_evidence.sv */
`default_nettype none
module bfs_evidence
	import bfs_pkg::*;
#(
	parameter int CUR_W = 16
) (
	input  wire logic         has_cur_in,   // Variant has current inputs.
	input  wire bfs_pkg::bfs_scheme_t scheme_in, // Selected scheme.
	input  wire logic [CUR_W-1:0] cur_in,   // Measured current.
	input  wire logic [CUR_W-1:0] thr_in,   // Threshold of the active set.
	input  wire logic         aux_open_in,  // Breaker open contact.
	input  wire logic         aux_closed_in,// Breaker closed contact.
	output logic              opened_out,   // Scheme reports breaker opened.
	output logic              pos_open_out  // Contacts agree on open.
);
	logic cur_low;

	// Without current inputs the current evidence is never trusted.
	assign cur_low      = has_cur_in && (cur_in < thr_in);
	assign pos_open_out = aux_open_in && !aux_closed_in;

	// Combined scheme fails only when both kinds of evidence fail.
	always_comb begin
		case (scheme_in)
			BFS_SCH_CURRENT:  opened_out = cur_low;                // [R3]
			BFS_SCH_POSITION: opened_out = pos_open_out;           // [R4]
			default:          opened_out = cur_low || pos_open_out; // [R5]
		endcase
	end
endmodule : bfs_evidence
`default_nettype wire

/* File: src/bfs_top.sv */
// Function
// R1: Setting selects current, position or combined scheme.
// R2: Any trigger starts the supervision timer.
// R3: Current scheme fails if current stays high.
// R4: Position scheme fails if contacts never show open.
// R5: Combined fails only when both evidences fail.
// R6: Four threshold sets; active set is used.
// R7: Current scheme only with current measurement fitted.
// R8: Failure output routable to relay or link.
// R9: Timer keeps running after trigger drops.
// R10: Timer elapsing issues the backup trip.
// R11: Opened with triggers active: rejected until released.
// R12: Backup trip sets lockout held until acknowledged.
// R13: Opening evidence stops and clears the timer.
//
// Our own choices: the Wishbone register port and the placing of the registers.
`include "bfs_defs.svh"
`default_nettype none
module bfs_top
	import bfs_pkg::*;
#(
	parameter int          N_TRIG      = 4,
	parameter int          CUR_W       = 16,
	parameter bit          HAS_CURRENT = 1'b1,
	parameter logic [31:0] SUP_TIME_CYC = 32'(`BFS_SUP_TIME_US * `BFS_CLK_MHZ)
) (
	input  wire logic              MCLK_IN,          // System clock, 200 MHz.
	input  wire logic              SYS_RST_IN,       // Synchronous reset, active high.
	input  wire logic              WB_CYC_IN,        // Wishbone cycle.
	input  wire logic              WB_STB_IN,        // Wishbone strobe.
	input  wire logic              WB_WE_IN,         // Wishbone write enable.
	input  wire logic [7:0]        WB_ADR_IN,        // Wishbone byte address.
	input  wire logic [3:0]        WB_SEL_IN,        // Wishbone byte selects.
	input  wire logic [31:0]       WB_DAT_IN,        // Wishbone write data.
	output logic [31:0]            WB_DAT_OUT,       // Wishbone read data.
	output logic                   WB_ACK_OUT,       // Wishbone acknowledge.
	input  wire logic [N_TRIG-1:0] TRIG_IN,          // Protection trip triggers.
	input  wire logic [CUR_W-1:0]  CURRENT_IN,       // Measured breaker current.
	input  wire logic              AUX_OPEN_IN,      // Breaker open contact.
	input  wire logic              AUX_CLOSED_IN,    // Breaker closed contact.
	input  wire logic [1:0]        ACTIVE_SET_IN,    // Parameter set from switching.
	output logic                   BACKUP_TRIP_OUT,  // Upstream trip to output relay.
	output logic                   LINK_TRIP_OUT,    // Upstream trip to communication.
	output logic                   LOCKOUT_OUT,      // Latched breaker lockout.
	output logic                   IRQ_OUT           // Level interrupt.
);
	import bfs_pkg::*;

	localparam logic [11:0] CTRL_RST = `BFS_CTRL_RST;

	bfs_tmr_if tmr_if ();

	// Register state.
	logic [11:0]           ctrl_q;
	logic [CUR_W-1:0]      thr_q [4];
	logic [31:0]           time_q;
	logic [`BFS_IRQ_W-1:0] irq_stat_q;
	logic [`BFS_IRQ_W-1:0] irq_en_q;
	logic                  lock_q;
	logic                  ack_q;
	logic [31:0]           rdat_q;
	bfs_state_t            state_q;
	logic                  trip_q;

	// Decoded control fields and helper nets.
	logic                  req;
	logic                  wr_now;
	logic [31:0]           wmask;
	logic [31:0]           ctrl_new;
	bfs_scheme_t           scheme;
	bfs_scheme_t           sch_wr;
	logic [1:0]            act_set;
	logic [N_TRIG-1:0]     trig_mask;
	logic                  trig_any;
	logic                  opened;
	logic                  pos_open;
	logic                  ev_trip;
	logic                  ev_rej;
	logic                  ev_start;
	logic                  oper_ack;
	logic [`BFS_IRQ_W-1:0] irq_clr;
	logic [11:0]           ctrl_rst_v;

	assign scheme    = bfs_scheme_t'(ctrl_q[`BFS_CTRL_SCH_HI:`BFS_CTRL_SCH_LO]);
	assign trig_mask = N_TRIG'(ctrl_q[`BFS_CTRL_MASK_HI:`BFS_CTRL_MASK_LO]);
	assign trig_any  = |(TRIG_IN & trig_mask) && ctrl_q[`BFS_CTRL_EN];

	// The active set comes from the switching input or from software.
	assign act_set = ctrl_q[`BFS_CTRL_SET_PIN] ? ACTIVE_SET_IN
	                                           : ctrl_q[`BFS_CTRL_SET_HI:`BFS_CTRL_SET_LO]; // [R6]

	// A variant without current inputs starts in the position scheme.
	assign ctrl_rst_v = HAS_CURRENT ? CTRL_RST
	                                : {CTRL_RST[11:3], BFS_SCH_POSITION, CTRL_RST[0]}; // [R7]

	// Wishbone classic: one wait state, the write lands at the acknowledging edge.
	assign req    = WB_CYC_IN && WB_STB_IN;
	assign wr_now = req && WB_WE_IN && ack_q;
	assign wmask  = {{8{WB_SEL_IN[3]}}, {8{WB_SEL_IN[2]}}, {8{WB_SEL_IN[1]}}, {8{WB_SEL_IN[0]}}};

	always_ff @(posedge MCLK_IN) begin
		if (SYS_RST_IN) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req && !ack_q;
		end
	end

	assign WB_ACK_OUT = ack_q;

	// New control word after byte selects, with scheme legalised.
	assign ctrl_new = ({20'h0, ctrl_q} & ~wmask) | (WB_DAT_IN & wmask);

	always_comb begin
		case (bfs_scheme_t'(ctrl_new[`BFS_CTRL_SCH_HI:`BFS_CTRL_SCH_LO]))
			BFS_SCH_CURRENT:  sch_wr = HAS_CURRENT ? BFS_SCH_CURRENT : BFS_SCH_POSITION; // [R7]
			BFS_SCH_POSITION: sch_wr = BFS_SCH_POSITION;
			BFS_SCH_COMBINED: sch_wr = HAS_CURRENT ? BFS_SCH_COMBINED : BFS_SCH_POSITION; // [R7]
			default:          sch_wr = scheme; // Reserved code keeps the old scheme.
		endcase
	end

	// Control register: scheme selection, routing, trigger mask, set choice.
	always_ff @(posedge MCLK_IN) begin
		if (SYS_RST_IN) begin
			ctrl_q <= CTRL_RST;
			if (!HAS_CURRENT) begin
				ctrl_q <= ctrl_rst_v;
			end
		end else if (wr_now && WB_ADR_IN == `BFS_OFF_CTRL) begin
			ctrl_q <= {ctrl_new[11:3], sch_wr, ctrl_new[0]}; // [R1]
		end
	end

	// Threshold of each of the four parameter sets.
	always_ff @(posedge MCLK_IN) begin
		if (SYS_RST_IN) begin
			for (int i = 0; i < 4; i++) begin
				thr_q[i] <= `BFS_THR_RST;
			end
		end else if (wr_now && WB_ADR_IN >= `BFS_OFF_THR0 && WB_ADR_IN <= `BFS_OFF_THR3
		             && WB_ADR_IN[1:0] == 2'b00) begin
			thr_q[2'(WB_ADR_IN[7:2] - 6'h1)] <=
				CUR_W'(({{(32-CUR_W){1'b0}}, thr_q[2'(WB_ADR_IN[7:2] - 6'h1)]} & ~wmask)
				       | (WB_DAT_IN & wmask)); // [R6]
		end
	end

	// Supervision time in clock cycles; zero is raised to one cycle.
	always_ff @(posedge MCLK_IN) begin
		if (SYS_RST_IN) begin
			time_q <= SUP_TIME_CYC;
		end else if (wr_now && WB_ADR_IN == `BFS_OFF_TIME) begin
			time_q <= ((time_q & ~wmask) | (WB_DAT_IN & wmask)) | {31'h0,
			          ((time_q & ~wmask) | (WB_DAT_IN & wmask)) == 32'h0};
		end
	end

	// Interrupt enable register.
	always_ff @(posedge MCLK_IN) begin
		if (SYS_RST_IN) begin
			irq_en_q <= '0;
		end else if (wr_now && WB_ADR_IN == `BFS_OFF_IRQ_EN && WB_SEL_IN[0]) begin
			irq_en_q <= WB_DAT_IN[`BFS_IRQ_W-1:0];
		end
	end

	// Write-only strobes: interrupt clear and operator acknowledgement.
	assign irq_clr  = (wr_now && WB_ADR_IN == `BFS_OFF_IRQ_CLR && WB_SEL_IN[0])
	                  ? WB_DAT_IN[`BFS_IRQ_W-1:0] : '0;
	assign oper_ack = wr_now && WB_ADR_IN == `BFS_OFF_OPER_ACK && WB_SEL_IN[0] && WB_DAT_IN[0];

	// Read data is captured in the wait state and presented with the acknowledge.
	always_ff @(posedge MCLK_IN) begin
		if (SYS_RST_IN) begin
			rdat_q <= 32'h0;
		end else if (req && !ack_q) begin
			case (WB_ADR_IN)
				`BFS_OFF_CTRL:     rdat_q <= {20'h0, ctrl_q};
				`BFS_OFF_THR0:     rdat_q <= 32'(thr_q[0]);
				`BFS_OFF_THR1:     rdat_q <= 32'(thr_q[1]);
				`BFS_OFF_THR2:     rdat_q <= 32'(thr_q[2]);
				`BFS_OFF_THR3:     rdat_q <= 32'(thr_q[3]);
				`BFS_OFF_TIME:     rdat_q <= time_q;
				`BFS_OFF_STATUS:   rdat_q <= {23'h0, HAS_CURRENT, act_set, opened, lock_q, trip_q,
				                              tmr_if.running, state_q};
				`BFS_OFF_IRQ_STAT: rdat_q <= 32'(irq_stat_q);
				`BFS_OFF_IRQ_EN:   rdat_q <= 32'(irq_en_q);
				`BFS_OFF_COUNT:    rdat_q <= tmr_if.count;
				default:           rdat_q <= 32'h0; // Unmapped and write-only read as zero.
			endcase
		end
	end

	assign WB_DAT_OUT = rdat_q;

	// Breaker opening evidence for the selected scheme and active set.
	bfs_evidence #(
		.CUR_W (CUR_W)
	) u_evidence (
		.has_cur_in    (HAS_CURRENT),
		.scheme_in     (scheme),
		.cur_in        (CURRENT_IN),
		.thr_in        (thr_q[act_set]), // [R6]
		.aux_open_in   (AUX_OPEN_IN),
		.aux_closed_in (AUX_CLOSED_IN),
		.opened_out    (opened),
		.pos_open_out  (pos_open)
	);

	// Supervision timer.
	bfs_timer u_timer (
		.clk_in (MCLK_IN),
		.rst_in (SYS_RST_IN),
		.tmr    (tmr_if.tmr)
	);

	// The timer starts on any trigger whatever the scheme, and only opening stops it,
	// so a trigger that drops early does not cancel the supervision.
	assign tmr_if.start = (state_q == BFS_STANDBY) && trig_any;           // [R2] [R9]
	assign tmr_if.stop  = (state_q == BFS_RUNNING) && opened;             // [R13]
	assign tmr_if.limit = time_q;

	// Events reported to software and to the state machine.
	assign ev_start = tmr_if.start;
	assign ev_trip  = (state_q == BFS_RUNNING) && tmr_if.expired;         // [R10]
	assign ev_rej   = (state_q == BFS_RUNNING) && opened && trig_any;     // [R11]

	// Monitor state machine.
	always_ff @(posedge MCLK_IN) begin
		if (SYS_RST_IN) begin
			state_q <= BFS_STANDBY;
		end else begin
			case (state_q)
				BFS_STANDBY: begin
					if (trig_any) begin
						state_q <= BFS_RUNNING; // [R2]
					end
				end
				BFS_RUNNING: begin
					// Opening evidence in the expiry cycle still counts as in time.
					if (opened) begin
						state_q <= trig_any ? BFS_REJECTED : BFS_STANDBY; // [R11] [R13]
					end else if (tmr_if.expired) begin
						state_q <= BFS_TRIPPED; // [R10]
					end
				end
				BFS_REJECTED: begin
					if (!trig_any) begin
						state_q <= BFS_STANDBY; // [R11]
					end
				end
				BFS_TRIPPED: begin
					// Trip holds while any trigger is still asserted.
					if (!trig_any) begin
						state_q <= BFS_STANDBY;
					end
				end
				default: state_q <= BFS_STANDBY;
			endcase
		end
	end

	// Backup trip level, registered so the outputs are glitch-free.
	always_ff @(posedge MCLK_IN) begin
		if (SYS_RST_IN) begin
			trip_q <= 1'b0;
		end else begin
			trip_q <= ev_trip || (state_q == BFS_TRIPPED && trig_any); // [R10]
		end
	end

	// Lockout latches with the trip; the trip wins over an acknowledge in the same cycle.
	always_ff @(posedge MCLK_IN) begin
		if (SYS_RST_IN) begin
			lock_q <= 1'b0;
		end else if (ev_trip) begin
			lock_q <= 1'b1; // [R12]
		end else if (oper_ack) begin
			lock_q <= 1'b0; // [R12]
		end
	end

	// Sticky interrupt status; a new event wins over a clear in the same cycle.
	always_ff @(posedge MCLK_IN) begin
		if (SYS_RST_IN) begin
			irq_stat_q <= '0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~irq_clr) | {ev_start, ev_rej, ev_trip};
		end
	end

	// Routing of the failure signal to the relay and to the link.
	assign BACKUP_TRIP_OUT = trip_q && ctrl_q[`BFS_CTRL_RELAY]; // [R8]
	assign LINK_TRIP_OUT   = trip_q && ctrl_q[`BFS_CTRL_LINK];  // [R8]
	assign LOCKOUT_OUT     = lock_q;
	assign IRQ_OUT         = |(irq_stat_q & irq_en_q);

	// The contact-only indication feeds no status bit or output; status shows the scheme result opened.
	logic pos_open_unused;
	assign pos_open_unused = pos_open;
endmodule : bfs_top
`default_nettype wire

/* File: dv/bfs_brk_model.sv */
`default_nettype none
module bfs_brk_model #(
	parameter int          CUR_W = 16,
	parameter logic [15:0] LOAD  = 16'h0800
) (
	input  wire logic             clk_in,      // System clock.
	input  wire logic             rst_in,      // Synchronous reset, active high.
	input  wire logic             trip_in,     // Trip command from protection.
	input  wire logic             close_in,    // Reclose command.
	input  wire logic [7:0]       delay_in,    // Held-command cycles to open, minus one.
	input  wire logic             cur_fail_in, // Arc keeps current flowing.
	input  wire logic             pos_fail_in, // Contacts stay closed.
	output logic [CUR_W-1:0]      cur_out,     // Measured current.
	output logic                  open_out,    // Open contact.
	output logic                  closed_out   // Closed contact.
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       open_q;
	logic [7:0] wait_q;

	// The poles part once the command has been seen for delay_in + 1 cycles in all; the count clears only on reset or close.
	always_ff @(posedge clk_in) begin
		if (rst_in || close_in) begin
			open_q <= 1'b0;
			wait_q <= 8'h00;
		end else if (trip_in && !open_q) begin
			wait_q <= wait_q + 8'h01;
			if (wait_q >= delay_in) begin
				open_q <= 1'b1;
			end
		end
	end

	// Fault flags model a welded pole and a stuck auxiliary contact.
	assign cur_out    = (open_q && !cur_fail_in) ? '0 : CUR_W'(LOAD);
	assign open_out   = open_q && !pos_fail_in;
	assign closed_out = !open_out;
endmodule : bfs_brk_model
`default_nettype wire

/* File: dv/bfs_top_asserts.sv */
`include "bfs_defs.svh"
`default_nettype none
module bfs_asserts #(
	parameter int          N_TRIG       = 4,
	parameter logic [31:0] SUP_TIME_CYC = 32'h0000_4e20
) (
	input wire logic              MCLK_IN,         // System clock.
	input wire logic              SYS_RST_IN,      // Synchronous reset.
	input wire logic              WB_CYC_IN,       // Wishbone cycle.
	input wire logic              WB_STB_IN,       // Wishbone strobe.
	input wire logic              WB_WE_IN,        // Wishbone write enable.
	input wire logic [7:0]        WB_ADR_IN,       // Wishbone address.
	input wire logic [3:0]        WB_SEL_IN,       // Wishbone byte selects.
	input wire logic [31:0]       WB_DAT_IN,       // Wishbone write data.
	input wire logic              WB_ACK_OUT,      // Wishbone acknowledge.
	input wire logic [N_TRIG-1:0] TRIG_IN,         // Trip triggers.
	input wire logic              BACKUP_TRIP_OUT, // Relay trip.
	input wire logic              LINK_TRIP_OUT,   // Link trip.
	input wire logic              LOCKOUT_OUT      // Latched lockout.
);
	timeunit 1ns;
	timeprecision 1ps;
	// Edges from the start edge to the one at which the risen trip is first sampled.
	localparam int D = int'(SUP_TIME_CYC) + 1;
	logic [15:0] zrun_q;
	logic        ack_wr;
	default clocking @(posedge MCLK_IN); endclocking
	default disable iff (SYS_RST_IN);

	// Idle trigger run; it saturates so a long quiet spell never wraps back to zero.
	always_ff @(posedge MCLK_IN) begin
		if (SYS_RST_IN || TRIG_IN != '0) begin
			zrun_q <= '0;
		end else if (zrun_q != 16'hffff) begin
			zrun_q <= zrun_q + 16'h0001;
		end
	end

	// An operator acknowledge lands at the edge where ack is seen.
	assign ack_wr = WB_CYC_IN && WB_STB_IN && WB_WE_IN && WB_ACK_OUT && WB_ADR_IN == `BFS_OFF_OPER_ACK
		&& WB_SEL_IN[0] && WB_DAT_IN[0];

	a_ack_wait: assert property (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT)
		else $error("ack late");
	a_ack_pulse: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
		else $error("ack longer than one cycle");
	a_trip_delay: assert property ($rose(LOCKOUT_OUT) |-> $past(TRIG_IN != '0, D))
		else $error("trip not timed from trigger");
	a_quiet_no_trip: assert property (32'(zrun_q) >= D |-> !$rose(LOCKOUT_OUT))
		else $error("trip without trigger");
	a_lock_with_trip: assert property ($rose(BACKUP_TRIP_OUT || LINK_TRIP_OUT) |-> LOCKOUT_OUT)
		else $error("trip without lockout");
	a_lock_cause: assert property ($rose(LOCKOUT_OUT) |-> BACKUP_TRIP_OUT || LINK_TRIP_OUT)
		else $error("lockout without trip");
	a_lock_held: assert property (LOCKOUT_OUT && !ack_wr |=> LOCKOUT_OUT)
		else $error("lockout lost");
	a_trip_holds: assert property (BACKUP_TRIP_OUT && TRIG_IN != '0 |=> BACKUP_TRIP_OUT)
		else $error("trip dropped");
	a_trip_release: assert property (BACKUP_TRIP_OUT && TRIG_IN == '0 |=> !BACKUP_TRIP_OUT)
		else $error("trip stuck");
endmodule : bfs_asserts

bind bfs_top bfs_asserts #(.N_TRIG(N_TRIG), .SUP_TIME_CYC(SUP_TIME_CYC)) u_asserts (
	.MCLK_IN(MCLK_IN), .SYS_RST_IN(SYS_RST_IN), .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN),
	.WB_WE_IN(WB_WE_IN), .WB_ADR_IN(WB_ADR_IN), .WB_SEL_IN(WB_SEL_IN), .WB_DAT_IN(WB_DAT_IN),
	.WB_ACK_OUT(WB_ACK_OUT), .TRIG_IN(TRIG_IN), .BACKUP_TRIP_OUT(BACKUP_TRIP_OUT),
	.LINK_TRIP_OUT(LINK_TRIP_OUT), .LOCKOUT_OUT(LOCKOUT_OUT));
`default_nettype wire

/* File: dv/tb_top.sv */
`include "bfs_defs.svh"
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// Supervision time shortened to 20 cycles for simulation.
	localparam logic [31:0] TIME = 32'h14;
	localparam int          T    = 20;
	logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, trip, link, lock, irq;
	logic        cur_fail = 1'b0, pos_fail = 1'b0, close = 1'b0, aopen, aclosed;
	logic [7:0]  adr = 8'h00, dly = 8'h02;
	logic [31:0] wdat = 32'h0, rdat, rdat_nc;
	logic [3:0]  trig = 4'h0;
	logic [1:0]  aset = 2'h0;
	logic [15:0] cur;
	int          fail_count = 0, n_checks = 0, cycles = 0;

	bfs_top #(.SUP_TIME_CYC(TIME)) DUT (
		.MCLK_IN(clk), .SYS_RST_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr),
		.WB_SEL_IN(4'hf), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .TRIG_IN(trig),
		.CURRENT_IN(cur), .AUX_OPEN_IN(aopen), .AUX_CLOSED_IN(aclosed), .ACTIVE_SET_IN(aset),
		.BACKUP_TRIP_OUT(trip), .LINK_TRIP_OUT(link), .LOCKOUT_OUT(lock), .IRQ_OUT(irq));
	bfs_brk_model u_brk (.clk_in(clk), .rst_in(rst), .trip_in(trig != 4'h0), .close_in(close), .delay_in(dly),
		.cur_fail_in(cur_fail), .pos_fail_in(pos_fail), .cur_out(cur), .open_out(aopen), .closed_out(aclosed));
	// A variant without current inputs shares the bus; only its control register is read back.
	bfs_top #(.SUP_TIME_CYC(TIME), .HAS_CURRENT(1'b0)) DUT_NC (
		.MCLK_IN(clk), .SYS_RST_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr),
		.WB_SEL_IN(4'hf), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat_nc), .WB_ACK_OUT(), .TRIG_IN(4'h0),
		.CURRENT_IN(cur), .AUX_OPEN_IN(aopen), .AUX_CLOSED_IN(aclosed), .ACTIVE_SET_IN(aset),
		.BACKUP_TRIP_OUT(), .LINK_TRIP_OUT(), .LOCKOUT_OUT(), .IRQ_OUT());

	// Clock, and a cycle ceiling so a hung handshake still ends the run.
	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 4000) begin
			fail_count++;
			complete_run();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Classic single cycle; the request stays put until ack is sampled.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clk); while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask : rdc

	// The output is picked after the edge (0 trip, 1 lock, 2 irq), since an input copy would be stale.
	task automatic see(input int sel, input logic e);
		@(posedge clk);
		#1;
		chk({31'h0, sel == 0 ? trip : sel == 1 ? lock : irq}, {31'h0, e});
	endtask : see

	// One supervision with a freshly closed breaker; triggers held well past expiry.
	task automatic run_case(input logic [11:0] ctrl, input logic cf, input logic pf, input logic [7:0] dl,
		input logic bk, input logic lk);
		wr(`BFS_OFF_CTRL, {20'h0, ctrl});
		@(posedge clk);
		close <= 1'b1;
		cur_fail <= cf;
		pos_fail <= pf;
		dly <= dl;
		@(posedge clk);
		close <= 1'b0;
		trig <= 4'h2;
		repeat (T + 4) @(posedge clk);
		#1;
		chk({31'h0, trip}, {31'h0, bk});
		chk({31'h0, link}, {31'h0, lk});
		chk({31'h0, lock}, {31'h0, bk | lk});
		rdc(`BFS_OFF_STATUS, {23'h0, 1'b1, aset, !(bk | lk), bk | lk, bk | lk, 1'b0, !(bk | lk) ? 2'h2 : 2'h3});
		if (!(bk | lk)) rdc(`BFS_OFF_COUNT, 32'h0);
		@(posedge clk);
		trig <= 4'h0;
		see(0, 1'b0);
		see(1, bk | lk);
		wr(`BFS_OFF_OPER_ACK, 32'h1);
		see(1, 1'b0);
	endtask : run_case

	task automatic t_regs();
		rdc(`BFS_OFF_CTRL, 32'h9f9);
		chk(rdat_nc, 32'h9fb);
		wr(`BFS_OFF_CTRL, 32'h9fd);
		rdc(`BFS_OFF_CTRL, 32'h9fd);
		chk(rdat_nc, 32'h9fb);
		wr(`BFS_OFF_CTRL, 32'h9ff);
		rdc(`BFS_OFF_CTRL, 32'h9fd);
		rdc(`BFS_OFF_THR0, 32'h100);
		rdc(`BFS_OFF_TIME, TIME);
		rdc(8'h3c, 32'h0);
	endtask : t_regs

	// Stuck breaker, trigger gone after three cycles: the timer must still run out.
	task automatic t_timing();
		int n;
		wr(`BFS_OFF_IRQ_CLR, 32'h7);
		wr(`BFS_OFF_IRQ_EN, 32'h1);
		@(posedge clk);
		cur_fail <= 1'b1;
		pos_fail <= 1'b1;
		trig <= 4'h8;
		for (n = 1; n < T + 8; n++) begin
			@(posedge clk);
			if (n == 3) trig <= 4'h0;
			#1;
			if (trip === 1'b1) break;
		end
		chk(32'(n), 32'(T + 1));
		chk({31'h0, irq}, 32'h1);
		see(0, 1'b0);
		wr(`BFS_OFF_IRQ_EN, 32'h0);
		see(2, 1'b0);
		wr(`BFS_OFF_IRQ_EN, 32'h1);
		see(2, 1'b1);
		wr(`BFS_OFF_IRQ_CLR, 32'h1);
		see(2, 1'b0);
		rdc(`BFS_OFF_IRQ_STAT, 32'h4);
		see(1, 1'b1);
		wr(`BFS_OFF_OPER_ACK, 32'h1);
		see(1, 1'b0);
	endtask : t_timing

	task automatic t_schemes();
		run_case(12'h9f9, 1'b0, 1'b0, 8'h02, 1'b0, 1'b0);
		run_case(12'h9f9, 1'b1, 1'b0, 8'h02, 1'b1, 1'b1);
		run_case(12'h9f9, 1'b0, 1'b0, 8'(T - 6), 1'b0, 1'b0);
		run_case(12'h9fb, 1'b1, 1'b0, 8'h02, 1'b0, 1'b0);
		run_case(12'h9fb, 1'b0, 1'b1, 8'h02, 1'b1, 1'b1);
		run_case(12'h9fd, 1'b1, 1'b0, 8'h02, 1'b0, 1'b0);
		run_case(12'h9fd, 1'b0, 1'b1, 8'h02, 1'b0, 1'b0);
		run_case(12'h9fd, 1'b1, 1'b1, 8'h02, 1'b1, 1'b1);
	endtask : t_schemes

	task automatic t_routes();
		run_case(12'h9f1, 1'b1, 1'b1, 8'h02, 1'b0, 1'b1);
		run_case(12'h9e9, 1'b1, 1'b1, 8'h02, 1'b1, 1'b0);
	endtask : t_routes

	// Set 1 holds a threshold above the load, so a stuck breaker already reads as open.
	task automatic t_set();
		wr(`BFS_OFF_THR1, 32'h0900);
		@(posedge clk);
		aset <= 2'h1;
		run_case(12'h9f9, 1'b1, 1'b1, 8'h02, 1'b0, 1'b0);
		@(posedge clk);
		aset <= 2'h0;
		rdc(`BFS_OFF_IRQ_STAT, 32'h7);
	endtask : t_set

	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : complete_run

	// Reset for 16 cycles, then the scenarios in turn.
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_timing();
		t_schemes();
		t_routes();
		t_set();
		complete_run();
	end
endmodule : tb_top
`default_nettype wire
